/* File: bench/rss_supply_model.sv */
// Pin, supply monitor and oscillator model on the far side of the sequencer
`timescale 1ns/10ps
module rss_supply_model (
    input  wire logic clock,
    input  wire logic pin_hold_low,
    input  wire logic vdd_good,
    input  wire logic vdd_above_trip,
    input  wire logic detect_on,
    input  wire logic pin_oe,
    output logic      reset_pin,
    output logic      above_por,
    output logic      above_bor,
    output logic      slow_osc,
    output logic      fast_osc
);
    // Pull-up resistor wins once the button lets go
    assign reset_pin = (pin_hold_low || pin_oe) ? 1'b0 : 1'b1;
    assign above_por = vdd_good;
    // A switched-off comparator rests low; the sequencer must ignore it
    assign above_bor = detect_on ? vdd_above_trip : 1'b0;
    // Free-running slow oscillator and crystal, 32 ns and 16 ns
    initial begin
        slow_osc = 1'b0;
        forever #16 slow_osc = ~slow_osc;
    end
    initial begin
        fast_osc = 1'b0;
        #1.3;
        forever #8 fast_osc = ~fast_osc;
    end
endmodule

/* File: bench/tb_reset_source_sequencer.sv */
// Self-checking bench for the reset source sequencer
`timescale 1ns/10ps
module tb_reset_source_sequencer;
    logic              clock, srst, hold_low, vdd_good, vdd_trip, sleep_mode;
    logic              pin, a_por, a_bor, s_osc, f_osc;
    logic              device_reset, pin_digital_in, brownout_flag, power_on_flag;
    logic              sw_brownout_enable, brownout_detect_on, pin_oe, pin_out;
    logic [1:0]        brownout_level_sel;
    rss_pkg::rss_cfg_t cfg;
    rss_pkg::rss_sw_t  sw;
    int                n_mismatch, n_tests, took;

    rss_supply_model far_u (.clock(clock), .pin_hold_low(hold_low), .vdd_good(vdd_good),
        .vdd_above_trip(vdd_trip), .detect_on(brownout_detect_on), .pin_oe(pin_oe),
        .reset_pin(pin), .above_por(a_por), .above_bor(a_bor), .slow_osc(s_osc),
        .fast_osc(f_osc));
    rss_reset_sequencer #(.PLL_LOCK_CYCLES(200)) dut_u (.clock(clock), .srst(srst),
        .cfg(cfg), .sw(sw), .external_reset_pin(pin), .supply_above_por(a_por),
        .supply_above_bor(a_bor), .slow_internal_osc(s_osc), .ext_osc(f_osc),
        .sleep_mode(sleep_mode), .device_reset(device_reset),
        .pin_digital_in(pin_digital_in), .brownout_flag(brownout_flag),
        .power_on_flag(power_on_flag), .sw_brownout_enable(sw_brownout_enable),
        .brownout_level_sel(brownout_level_sel), .brownout_detect_on(brownout_detect_on),
        .external_reset_pin_oe(pin_oe), .external_reset_pin_out(pin_out));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs always move 1 ns after the edge
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Bounded wait for the internal reset to drop
    task automatic wait_release(input int limit, output int t);
        t = 0;
        while (device_reset !== 1'b0 && t < limit) begin
            tick(1);
            t++;
        end
    endtask

    task automatic brownout_drop(input int n);
        vdd_trip = 1'b0;
        tick(n);
        vdd_trip = 1'b1;
    endtask

    task automatic run_power_up();
        tick(8000);
        check("reset_counting", device_reset, 1'b1);
        wait_release(12000, took);
        check("pwrup_span", 16'(took + 8000 inside {[16381:16389]}), 1);
        check("por_flag", power_on_flag, 1'b0);
        check("bor_flag", brownout_flag, 1'b0);
        check("level_sel", brownout_level_sel, 2'h2);
        check("pin_oe", {pin_oe, pin_out}, 2'h0);
        check("sbor_read", sw_brownout_enable, 1'b0);
    endtask

    task automatic run_pin();
        logic bad;
        cfg.powerup_delay_off = 1'b1;
        sw = 4'hc;
        tick(1);
        sw = 4'h0;
        tick(2);
        check("flags_set", {power_on_flag, brownout_flag}, 2'h3);
        bad = 1'b0;
        hold_low = 1'b1;
        tick(2);
        hold_low = 1'b0;
        repeat (12) begin
            tick(1);
            bad |= device_reset;
        end
        check("glitch", bad, 1'b0);
        hold_low = 1'b1;
        tick(20);
        check("pin_reset", device_reset, 1'b1);
        check("por_kept", power_on_flag, 1'b1);
        hold_low = 1'b0;
        wait_release(100, took);
        check("pin_release", device_reset, 1'b0);
        cfg.external_reset_pin_enable = 1'b0;
        hold_low = 1'b1;
        tick(20);
        check("pin_off_rst", device_reset, 1'b0);
        check("pin_input", pin_digital_in, 1'b0);
        hold_low = 1'b0;
        tick(8);
        check("pin_input_hi", pin_digital_in, 1'b1);
        cfg.external_reset_pin_enable = 1'b1;
    endtask

    task automatic run_modes();
        logic exp;
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 4; i++) begin
                cfg.brownout_enable_mode = 2'(m);
                sleep_mode = i[1];
                sw = {2'b00, 1'b1, i[0]};
                tick(1);
                sw = 4'h0;
                tick(3);
                exp = (m == 3) || (m == 2 && !i[1]) || (m == 1 && i[0]);
                check("detect_on", brownout_detect_on, exp);
                check("sbor_bit", sw_brownout_enable, (m == 1) ? i[0] : 1'b0);
            end
        end
        sleep_mode = 1'b0;
        cfg.brownout_enable_mode = rss_pkg::BOR_MODE_ON;
        tick(3);
    endtask

    task automatic run_brownout();
        sw = 4'h4;
        tick(1);
        sw = 4'h0;
        vdd_trip = 1'b0;
        tick(300);
        check("bor_reset", device_reset, 1'b1);
        check("bor_flags", {power_on_flag, brownout_flag}, 2'h2);
        brownout_drop(100);
        check("bor_hold", device_reset, 1'b1);
        wait_release(100, took);
        check("no_delay", 16'(took < 50), 1);
        cfg.powerup_delay_off = 1'b0;
        brownout_drop(300);
        tick(5000);
        check("mid_delay", device_reset, 1'b1);
        brownout_drop(300);
        wait_release(17000, took);
        check("restart_span", 16'(took inside {[16360:16440]}), 1);
        cfg = {1'b1, rss_pkg::BOR_MODE_ON, 2'h2, 3'b111};
        brownout_drop(300);
        wait_release(5000, took);
        check("osc_pll_span", 16'(took inside {[4290:4320]}), 1);
    endtask

    // Detector off, sleep gating, then a full supply collapse
    task automatic run_supply();
        cfg = {1'b1, rss_pkg::BOR_MODE_OFF, 2'h1, 3'b100};
        sw = 4'hc;
        tick(1);
        sw = 4'h0;
        vdd_trip = 1'b0;
        tick(300);
        check("off_no_trip", {device_reset, brownout_flag}, 2'h1);
        check("level_sel_1", brownout_level_sel, 2'h1);
        cfg.brownout_enable_mode = rss_pkg::BOR_MODE_NOSLP;
        sleep_mode = 1'b1;
        tick(300);
        check("sleep_no_trip", device_reset, 1'b0);
        sleep_mode = 1'b0;
        tick(300);
        check("wake_trip", {device_reset, brownout_flag}, 2'h2);
        vdd_trip = 1'b1;
        wait_release(100, took);
        check("bor_release", device_reset, 1'b0);
        sw = 4'hc;
        tick(1);
        sw = 4'h0;
        vdd_good = 1'b0;
        vdd_trip = 1'b0;
        tick(10);
        check("por_reset", {device_reset, power_on_flag, brownout_flag}, 3'h4);
        vdd_good = 1'b1;
        vdd_trip = 1'b1;
        wait_release(100, took);
        check("por_release", {device_reset, power_on_flag}, 2'h0);
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog sized well past the roughly 45000 cycles the tests need
    initial begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        stop_test();
    end

    initial begin
        n_mismatch = 0;
        n_tests = 0;
        srst = 1'b1;
        hold_low = 1'b0;
        vdd_good = 1'b1;
        vdd_trip = 1'b1;
        sleep_mode = 1'b0;
        sw = 4'h0;
        cfg = {1'b1, rss_pkg::BOR_MODE_ON, 2'h2, 3'b000};
        tick(8);
        srst = 1'b0;
        run_power_up();
        run_pin();
        run_modes();
        run_brownout();
        run_supply();
        stop_test();
    end
endmodule

/* File: design/rss_pkg.sv */
// Constants and carrier types for the reset source sequencer
package rss_pkg;
    localparam logic [1:0]  BOR_MODE_OFF   = 2'h0;
    localparam logic [1:0]  BOR_MODE_SW    = 2'h1;
    localparam logic [1:0]  BOR_MODE_NOSLP = 2'h2;
    localparam logic [1:0]  BOR_MODE_ON    = 2'h3;
    localparam int          PIN_FILT_LEN   = 4;
    localparam logic [2:0]  PIN_FILT_MAX   = 3'h4;
    localparam int          BOR_MIN_NS     = 1000;
    localparam int          CLK_PERIOD_NS  = 4;
    localparam logic [15:0] BOR_MIN_CYC    = 16'(BOR_MIN_NS / CLK_PERIOD_NS);
    localparam logic [11:0] PWRUP_COUNT    = 12'h0800;
    localparam logic [10:0] OSC_WAIT_COUNT = 11'h0400;
    localparam int          PLL_LOCK_US    = 2000;
    localparam int          PLL_LOCK_CYC   = PLL_LOCK_US * 1000 / CLK_PERIOD_NS;
    localparam logic        POR_FLAG_RST   = 1'b0;
    localparam logic        BOR_FLAG_RST   = 1'b0;
    localparam logic        SBOR_EN_RST    = 1'b1;

    // Static configuration word fields
    typedef struct packed {
        logic       external_reset_pin_enable;
        logic [1:0] brownout_enable_mode;
        logic [1:0] brownout_threshold_select;
        logic       powerup_delay_off;
        logic       xtal_mode;
        logic       pll_mode;
    } rss_cfg_t;

    // Software writes to the status and control bits
    typedef struct packed {
        logic set_por_flag;
        logic set_bor_flag;
        logic sbor_wr;
        logic sbor_wdata;
    } rss_sw_t;

    typedef enum logic [2:0] {
        RSS_HOLD   = 3'b000,
        RSS_PWRUP  = 3'b001,
        RSS_OSCW   = 3'b010,
        RSS_PLLW   = 3'b011,
        RSS_RUN    = 3'b100
    } rss_state_t;
endpackage

/* File: design/rss_reset_sequencer.sv */
// Reset source merge, brown-out control and start-up delay sequencing
`timescale 1ns/10ps
module rss_reset_sequencer #(
    parameter int PLL_LOCK_CYCLES = rss_pkg::PLL_LOCK_CYC
) (
    input  wire logic             clock,
    input  wire logic             srst,
    input  wire rss_pkg::rss_cfg_t cfg,
    input  wire rss_pkg::rss_sw_t  sw,
    input  wire logic             external_reset_pin,
    input  wire logic             supply_above_por,
    input  wire logic             supply_above_bor,
    input  wire logic             slow_internal_osc,
    input  wire logic             ext_osc,
    input  wire logic             sleep_mode,
    output logic                  device_reset,
    output logic                  pin_digital_in,
    output logic                  brownout_flag,
    output logic                  power_on_flag,
    output logic                  sw_brownout_enable,
    output logic [1:0]            brownout_level_sel,
    output logic                  brownout_detect_on,
    output logic                  external_reset_pin_oe,
    output logic                  external_reset_pin_out
);

    // Two-stage synchronisers for every asynchronous input
    logic [1:0] pin_s;
    logic [1:0] por_s;
    logic [1:0] bor_s;
    logic [1:0] lfo_s;
    logic [1:0] xo_s;
    always_ff @(posedge clock) begin
        pin_s <= {pin_s[0], external_reset_pin};
        por_s <= {por_s[0], supply_above_por};
        bor_s <= {bor_s[0], supply_above_bor};
        lfo_s <= {lfo_s[0], slow_internal_osc};
        xo_s  <= {xo_s[0], ext_osc};
    end

    logic pin_q;
    logic por_ok;
    logic bor_ok;
    assign pin_q  = pin_s[1];
    assign por_ok = por_s[1];
    assign bor_ok = bor_s[1];

    // Rising-edge detect on the synchronised slow and crystal clocks
    logic lfo_d;
    logic xo_d;
    logic lfo_tick;
    logic xo_tick;
    always_ff @(posedge clock) begin
        lfo_d <= lfo_s[1];
        xo_d  <= xo_s[1];
    end
    assign lfo_tick = lfo_s[1] & ~lfo_d;
    assign xo_tick  = xo_s[1] & ~xo_d;

    // Pin glitch filter: level must be stable for a run of cycles
    logic [2:0] filt_cnt;
    logic       pin_filt;
    always_ff @(posedge clock) begin
        if (srst) begin
            filt_cnt <= 3'h0;
            pin_filt <= 1'b1;
        end else if (pin_q == pin_filt) begin
            filt_cnt <= 3'h0;
        end else if (filt_cnt == rss_pkg::PIN_FILT_MAX - 3'h1) begin
            filt_cnt <= 3'h0;
            pin_filt <= pin_q;
        end else begin
            filt_cnt <= filt_cnt + 3'h1;
        end
    end

    // Pin reset only when the pin function is enabled
    logic pin_rst;
    assign pin_rst = cfg.external_reset_pin_enable & ~pin_filt;

    // Power-on pulse: supply absent, or just rose above threshold
    logic por_prev;
    logic por_rst;
    always_ff @(posedge clock) begin
        if (srst) begin
            por_prev <= 1'b0;
        end else begin
            por_prev <= por_ok;
        end
    end
    assign por_rst = ~por_ok | ~por_prev;

    // Software brown-out enable bit, only live in software mode
    logic sbor_bit;
    always_ff @(posedge clock) begin
        if (srst || por_rst) begin
            sbor_bit <= rss_pkg::SBOR_EN_RST;
        end else if (sw.sbor_wr) begin
            sbor_bit <= sw.sbor_wdata;
        end
    end

    // Detector enable decode from the mode field
    logic bor_en;
    always_comb begin
        unique case (cfg.brownout_enable_mode)
            rss_pkg::BOR_MODE_OFF:   bor_en = 1'b0;
            rss_pkg::BOR_MODE_SW:    bor_en = sbor_bit;
            rss_pkg::BOR_MODE_NOSLP: bor_en = ~sleep_mode;
            rss_pkg::BOR_MODE_ON:    bor_en = 1'b1;
        endcase
    end

    // Drop must persist for the minimum duration before tripping
    logic [15:0] drop_cnt;
    logic        bor_rst;
    always_ff @(posedge clock) begin
        if (srst || !bor_en || bor_ok) begin
            drop_cnt <= 16'h0000;
        end else if (drop_cnt != rss_pkg::BOR_MIN_CYC) begin
            drop_cnt <= drop_cnt + 16'h0001;
        end
    end

    // Brown-out reset latches until supply comes back or the detector is switched off
    always_ff @(posedge clock) begin
        if (srst || !bor_en || bor_ok) begin
            bor_rst <= 1'b0;
        end else if (drop_cnt == rss_pkg::BOR_MIN_CYC) begin
            bor_rst <= 1'b1;
        end
    end

    // Power-on flag: hardware only clears it, software sets it
    always_ff @(posedge clock) begin
        if (srst || por_rst) begin
            power_on_flag <= rss_pkg::POR_FLAG_RST;
        end else if (sw.set_por_flag) begin
            power_on_flag <= 1'b1;
        end
    end

    // Brown-out flag cleared by either supply reset
    always_ff @(posedge clock) begin
        if (srst || por_rst || (bor_en && bor_rst)) begin
            brownout_flag <= rss_pkg::BOR_FLAG_RST;
        end else if (sw.set_bor_flag) begin
            brownout_flag <= 1'b1;
        end
    end

    // Supply-side reset restarts the whole start-up sequence
    logic supply_rst;
    assign supply_rst = por_rst | bor_rst;

    // Start-up delay sequence
    rss_pkg::rss_state_t state;
    rss_pkg::rss_state_t next_state;
    logic [11:0]         dly_cnt;
    logic [31:0]         pll_cnt;
    logic                pwrup_done;
    logic                osc_done;
    logic                pll_done;
    assign pwrup_done = (dly_cnt == rss_pkg::PWRUP_COUNT);
    assign osc_done   = (dly_cnt[10:0] == rss_pkg::OSC_WAIT_COUNT);
    assign pll_done   = (pll_cnt == 32'(PLL_LOCK_CYCLES - 1));

    always_comb begin
        next_state = state;
        unique case (state)
            rss_pkg::RSS_HOLD: begin
                if (cfg.powerup_delay_off == 1'b0) begin
                    next_state = rss_pkg::RSS_PWRUP;
                end else if (cfg.xtal_mode) begin
                    next_state = rss_pkg::RSS_OSCW;
                end else begin
                    next_state = rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_PWRUP: begin
                if (pwrup_done) begin
                    next_state = cfg.xtal_mode ? rss_pkg::RSS_OSCW : rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_OSCW: begin
                if (osc_done) begin
                    next_state = cfg.pll_mode ? rss_pkg::RSS_PLLW : rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_PLLW: begin
                if (pll_done) begin
                    next_state = rss_pkg::RSS_RUN;
                end
            end
            rss_pkg::RSS_RUN: next_state = rss_pkg::RSS_RUN;
            default:          next_state = rss_pkg::RSS_HOLD;
        endcase
    end

    // State register; any supply reset returns to hold
    always_ff @(posedge clock) begin
        if (srst || supply_rst) begin
            state <= rss_pkg::RSS_HOLD;
        end else begin
            state <= next_state;
        end
    end

    // Delay counters, cleared on every state change
    always_ff @(posedge clock) begin
        if (srst || supply_rst || next_state != state) begin
            dly_cnt <= 12'h000;
            pll_cnt <= 32'h0000_0000;
        end else begin
            if ((state == rss_pkg::RSS_PWRUP && lfo_tick) ||
                (state == rss_pkg::RSS_OSCW && xo_tick)) begin
                dly_cnt <= dly_cnt + 12'h001;
            end
            if (state == rss_pkg::RSS_PLLW) begin
                pll_cnt <= pll_cnt + 32'h0000_0001;
            end
        end
    end

    // Registered outputs; the pin is input only
    always_ff @(posedge clock) begin
        if (srst) begin
            device_reset           <= 1'b1;
            pin_digital_in         <= 1'b1;
            sw_brownout_enable     <= 1'b0;
            brownout_level_sel     <= 2'h0;
            brownout_detect_on     <= 1'b0;
            external_reset_pin_oe  <= 1'b0;
            external_reset_pin_out <= 1'b0;
        end else begin
            device_reset           <= supply_rst | pin_rst |
                                      (state != rss_pkg::RSS_RUN);
            pin_digital_in         <= pin_q;
            sw_brownout_enable     <= (cfg.brownout_enable_mode == rss_pkg::BOR_MODE_SW)
                                      & sbor_bit;
            brownout_level_sel     <= cfg.brownout_threshold_select;
            brownout_detect_on     <= bor_en;
            external_reset_pin_oe  <= 1'b0;
            external_reset_pin_out <= 1'b0;
        end
    end

    // Reset must stay high while the power-up delay runs
    a_pwrup_holds: assert property (@(posedge clock) disable iff (srst)
        state == rss_pkg::RSS_PWRUP |=> device_reset)
        else $error("reset dropped during power-up delay");

    a_pin_holds: assert property (@(posedge clock) disable iff (srst)
        pin_rst |=> device_reset)
        else $error("pin reset not applied");

    a_pin_never_driven: assert property (@(posedge clock) disable iff (srst)
        !external_reset_pin_oe)
        else $error("reset pin driven");

    // Filter may only follow a level held for four samples running
    a_pin_filter: assert property (@(posedge clock) disable iff (srst)
        !$past(srst) && $changed(pin_filt) |->
            $past(pin_q, 1) == pin_filt && $past(pin_q, 2) == pin_filt &&
            $past(pin_q, 3) == pin_filt && $past(pin_q, 4) == pin_filt)
        else $error("pin filter passed a short pulse");

    a_por_flag_clear: assert property (@(posedge clock) disable iff (srst)
        por_rst |=> !power_on_flag)
        else $error("power-on flag not cleared");

    a_por_flag_nohw: assert property (@(posedge clock) disable iff (srst)
        $rose(power_on_flag) |-> $past(sw.set_por_flag))
        else $error("power-on flag set without software");

    // One cycle of grace: a brown-out held when the mode is reprogrammed
    a_bor_mode_off: assert property (@(posedge clock) disable iff (srst)
        cfg.brownout_enable_mode == rss_pkg::BOR_MODE_OFF |=> !bor_rst)
        else $error("brown-out active in off mode");

    a_bor_recover: assert property (@(posedge clock) disable iff (srst)
        bor_rst && bor_ok |=> !bor_rst)
        else $error("brown-out held after recovery");

    a_bor_flag_clear: assert property (@(posedge clock) disable iff (srst)
        bor_en && bor_rst |=> !brownout_flag)
        else $error("brown-out flag not cleared");

    a_sbor_reads_zero: assert property (@(posedge clock) disable iff (srst)
        cfg.brownout_enable_mode != rss_pkg::BOR_MODE_SW |=> !sw_brownout_enable)
        else $error("software enable visible outside mode");

    // Watch the enable as the analog side sees it, not the decode
    a_sleep_off: assert property (@(posedge clock) disable iff (srst)
        cfg.brownout_enable_mode == rss_pkg::BOR_MODE_NOSLP && sleep_mode |=>
            !brownout_detect_on)
        else $error("detector on during sleep");

    // Release only once every source is quiet and the sequence has ended
    a_release_clean: assert property (@(posedge clock) disable iff (srst)
        !device_reset |-> $past(!supply_rst && !pin_rst && state == rss_pkg::RSS_RUN))
        else $error("reset released with a source active");

    sequence s_bor_trip;
        bor_rst ##1 state == rss_pkg::RSS_HOLD;
    endsequence
    a_bor_restart: assert property (@(posedge clock) disable iff (srst)
        $rose(bor_rst) |-> s_bor_trip)
        else $error("delay not restarted on brown-out");

    sequence s_delay_cleared;
        state == rss_pkg::RSS_HOLD && dly_cnt == 12'h000;
    endsequence
    a_pwrup_restart: assert property (@(posedge clock) disable iff (srst)
        state == rss_pkg::RSS_PWRUP && supply_rst |=> s_delay_cleared)
        else $error("delay count kept across a supply reset");

    // Delay leaves only on the full count unless a supply reset cuts it
    a_pwrup_exit: assert property (@(posedge clock) disable iff (srst)
        state == rss_pkg::RSS_PWRUP && !supply_rst |=>
            state == rss_pkg::RSS_PWRUP || $past(dly_cnt) == rss_pkg::PWRUP_COUNT)
        else $error("power-up delay ended early");

endmodule
